// >>> synth_cal_engine.sv
/*
  Calibration sequencer: times one calibration run, captures the analog
  search result into per-frequency-register slots and reports completion.
  Assumes the top supplies the run length in cycles and a start pulse.
*/
`timescale 1ns/100ps
module synth_cal_engine
  import synth_cal_pkg::*;
(
  input  wire logic             clk,        // System clock.
  input  wire logic             srst,       // Synchronous reset.
  input  wire logic             start,      // One-cycle start pulse.
  input  wire logic             synth_on,   // Synthesiser powered.
  input  wire logic             start_bit,  // Start bit level.
  input  wire logic [CNT_W-1:0] cal_len,    // Run length in cycles.
  input  wire logic             dual,       // Calibrate both slots.
  input  wire logic             fsel,       // Selected frequency slot.
  input  wire logic [7:0]       osc_meas,   // Oscillator search result.
  input  wire logic [7:0]       pump_meas,  // Pump current search result.
  output logic                  busy,       // Run in progress.
  output logic                  done,       // Completion flag.
  output logic [7:0]            slot_osc0,  // Oscillator value, slot A.
  output logic [7:0]            slot_osc1,  // Oscillator value, slot B.
  output logic [7:0]            slot_pmp0,  // Pump value, slot A.
  output logic [7:0]            slot_pmp1   // Pump value, slot B.
);

  cal_state_e       state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic             next_done;
  logic [7:0]       next_osc0, next_osc1, next_pmp0, next_pmp1;
  logic             finish;

  assign busy   = (state == CAL_RUN);
  assign finish = busy && synth_on && (cnt == CNT_W'(1));

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_done  = done;
    next_osc0  = slot_osc0;
    next_osc1  = slot_osc1;
    next_pmp0  = slot_pmp0;
    next_pmp1  = slot_pmp1;
    case (state)
      CAL_IDLE:
      begin
        if (start && synth_on)
        begin
          next_state = CAL_RUN;
          next_cnt   = cal_len;
          next_done  = 1'b0;
        end
      end
      CAL_RUN:
      begin
        if (!synth_on)
          next_state = CAL_IDLE;
        else if (finish)
        begin
          next_state = CAL_DONE;
          next_done  = 1'b1;
          if (dual || !fsel)
          begin
            next_osc0 = osc_meas;
            next_pmp0 = pump_meas;
          end
          if (dual || fsel)
          begin
            next_osc1 = osc_meas;
            next_pmp1 = pump_meas;
          end
        end
        else
          next_cnt = cnt - CNT_W'(1);
      end
      CAL_DONE:
      begin
        if (!start_bit)
        begin
          next_state = CAL_IDLE;
          next_done  = 1'b0;
        end
      end
      default:
        next_state = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state     <= CAL_IDLE;
      cnt       <= '0;
      done      <= 1'b0;
      slot_osc0 <= 8'h00;
      slot_osc1 <= 8'h00;
      slot_pmp0 <= 8'h00;
      slot_pmp1 <= 8'h00;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      done      <= next_done;
      slot_osc0 <= next_osc0;
      slot_osc1 <= next_osc1;
      slot_pmp0 <= next_pmp0;
      slot_pmp1 <= next_pmp1;
    end
  end

  start_runs_a: assert property (@(posedge clk) disable iff (srst)
    (state == CAL_IDLE && start && synth_on) |=> busy && !done)
    else $error("Calibration did not start on request.");
  result_held_a: assert property (@(posedge clk) disable iff (srst)
    !finish |=> $stable(slot_osc0) && $stable(slot_pmp1))
    else $error("Stored calibration changed without a finished run.");
  done_set_a: assert property (@(posedge clk) disable iff (srst)
    finish |=> done && !busy)
    else $error("Completion flag not raised after the run.");
  dual_both_a: assert property (@(posedge clk) disable iff (srst)
    (finish && dual) |=> slot_osc0 == $past(osc_meas) && slot_osc1 == $past(osc_meas))
    else $error("Dual calibration did not fill both slots.");
  single_one_a: assert property (@(posedge clk) disable iff (srst)
    (finish && !dual && !fsel) |=> $stable(slot_osc1) && $stable(slot_pmp1))
    else $error("Single calibration touched the other slot.");

endmodule : synth_cal_engine

// >>> synth_cal_pkg.sv
/*
  Shared constants for the synthesiser calibration and power control block:
  register offsets, field positions, reset values, timing figures and states.
  Assumes a 20 MHz system clock and an AXI4-Lite register bus of 32 bits.
*/
package synth_cal_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ      = 20000;
  localparam int CAL_MS_2P4   = 14;
  localparam int CAL_MS_2P0   = 17;
  localparam int CAL_MS_1P5   = 23;
  localparam int CAL_MS_1P0   = 34;
  localparam int CNT_W        = 20;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_BIAS     = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_RDBK_A   = 8'h0C;
  localparam logic [7:0] ADDR_RDBK_B   = 8'h10;
  localparam logic [7:0] ADDR_OVRD_A   = 8'h14;
  localparam logic [7:0] ADDR_OVRD_B   = 8'h18;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_START    = 0;
  localparam int CTRL_WAIT     = 1;
  localparam int CTRL_DUAL     = 2;
  localparam int CTRL_FSEL     = 3;
  localparam int CTRL_LOCK_LSB = 4;
  localparam int CTRL_REF_LSB  = 8;
  localparam int CTRL_RX_PD    = 12;
  localparam int CTRL_TX_PD    = 13;
  localparam int CTRL_SYN_PD   = 14;
  localparam int CTRL_XO_PD    = 15;
  localparam logic [15:0] CTRL_RST = 16'hF000;

  // Lock pin source codes.
  localparam logic [3:0] LOCK_SRC_ZERO = 4'h0;
  localparam logic [3:0] LOCK_SRC_CAL  = 4'h1;
  localparam logic [3:0] LOCK_SRC_LOCK = 4'h2;

  // ----------------------------------------------------------------------
  // Bias register fields
  // ----------------------------------------------------------------------
  localparam int BIAS_OSC_LSB = 0;
  localparam int BIAS_LO_LSB  = 4;
  localparam int BIAS_PA_LSB  = 6;
  localparam int BIAS_BUF     = 8;
  localparam int BIAS_LNA_LSB = 9;
  localparam logic [10:0] BIAS_RST = 11'h000;

  // Override registers: value in bits 7:0, override enable in bit 8.
  localparam int OVRD_EN = 8;
  localparam logic [8:0] OVRD_RST = 9'h000;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_DONE = 2'b10
  } cal_state_e;

  // Merges write data into an old value under the AXI byte strobes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = wdat[8*i +: 8];
    return res;
  endfunction : lane_merge

endpackage : synth_cal_pkg

// >>> synth_calibration_power_ctrl.sv
/*
  Synthesiser calibration, bias and power-down control with AXI4-Lite
  register access. Assumes analog search results arrive on plain inputs
  and that the bus master follows AXI4-Lite signalling.
*/
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module synth_calibration_power_ctrl
  import synth_cal_pkg::*;
#(
  parameter int CYC_2P4 = CAL_MS_2P4 * CLK_KHZ, // Run length at 2.4 MHz.
  parameter int CYC_2P0 = CAL_MS_2P0 * CLK_KHZ, // Run length at 2.0 MHz.
  parameter int CYC_1P5 = CAL_MS_1P5 * CLK_KHZ, // Run length at 1.5 MHz.
  parameter int CYC_1P0 = CAL_MS_1P0 * CLK_KHZ  // Run length at 1.0 MHz.
)
(
  input  wire logic        clk,                  // System clock, 20 MHz.
  input  wire logic        srst,                 // Synchronous reset.
  input  wire logic [7:0]  s_axi_awaddr,         // Write address.
  input  wire logic        s_axi_awvalid,        // Write address valid.
  output logic             s_axi_awready,        // Write address ready.
  input  wire logic [31:0] s_axi_wdata,          // Write data.
  input  wire logic [3:0]  s_axi_wstrb,          // Write byte strobes.
  input  wire logic        s_axi_wvalid,         // Write data valid.
  output logic             s_axi_wready,         // Write data ready.
  output logic [1:0]       s_axi_bresp,          // Write response.
  output logic             s_axi_bvalid,         // Write response valid.
  input  wire logic        s_axi_bready,         // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,         // Read address.
  input  wire logic        s_axi_arvalid,        // Read address valid.
  output logic             s_axi_arready,        // Read address ready.
  output logic [31:0]      s_axi_rdata,          // Read data.
  output logic [1:0]       s_axi_rresp,          // Read response.
  output logic             s_axi_rvalid,         // Read data valid.
  input  wire logic        s_axi_rready,         // Read data ready.
  input  wire logic [7:0]  osc_meas,             // Oscillator search result.
  input  wire logic [7:0]  pump_meas,            // Pump current search result.
  input  wire logic        continuous_lock_flag, // Loop lock indication.
  output logic             charge_pump_lock_pin, // Lock/status pin.
  output logic [7:0]       osc_tune,             // Applied oscillator value.
  output logic [7:0]       pump_current,         // Applied pump value.
  output logic [3:0]       oscillator_bias_setting, // Oscillator bias.
  output logic [1:0]       lo_buffer_drive,      // LO buffer bias.
  output logic [1:0]       amplifier_buffer_drive, // PA buffer bias.
  output logic             buf_current,          // Buffer current select.
  output logic [1:0]       lna_bias,             // LNA bias.
  output logic             rx_pd,                // Receive power-down.
  output logic             tx_pd,                // Transmit power-down.
  output logic             synth_pd,             // Synthesiser power-down.
  output logic             xosc_pd               // Crystal osc power-down.
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [15:0] ctrl, next_ctrl;
  logic [10:0] bias, next_bias;
  logic [8:0]  ovrd_a, next_ovrd_a;
  logic [8:0]  ovrd_b, next_ovrd_b;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        start_d, next_start_d;
  logic [7:0]  rdbk_a, next_rdbk_a;
  logic [7:0]  rdbk_b, next_rdbk_b;
  logic [7:0]  tune, next_tune;
  logic [7:0]  pump, next_pump;
  logic        lock_pin, next_lock_pin;

  logic             wr_go, rd_go;
  logic             cal_busy, cal_done, start_pulse;
  logic [CNT_W-1:0] cal_len;
  logic [7:0]       s_osc0, s_osc1, s_pmp0, s_pmp1;
  logic [31:0]      status_word;

  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = !rvalid;
  assign wr_go         = s_axi_awready;
  assign rd_go         = s_axi_arvalid && !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

  assign start_pulse = ctrl[CTRL_START] && !start_d;
  assign status_word = {29'h0, continuous_lock_flag, cal_busy, cal_done};

  // ----------------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_ctrl   = ctrl;
    next_bias   = bias;
    next_ovrd_a = ovrd_a;
    next_ovrd_b = ovrd_b;
    next_bvalid = bvalid && !s_axi_bready;
    next_bresp  = bresp;
    next_rvalid = rvalid && !s_axi_rready;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (wr_go)
    begin
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      case (s_axi_awaddr)
        ADDR_CTRL:   next_ctrl   = 16'(lane_merge({16'h0, ctrl}, s_axi_wdata, s_axi_wstrb));
        ADDR_BIAS:   next_bias   = 11'(lane_merge({21'h0, bias}, s_axi_wdata, s_axi_wstrb));
        ADDR_OVRD_A: next_ovrd_a = 9'(lane_merge({23'h0, ovrd_a}, s_axi_wdata, s_axi_wstrb));
        ADDR_OVRD_B: next_ovrd_b = 9'(lane_merge({23'h0, ovrd_b}, s_axi_wdata, s_axi_wstrb));
        ADDR_STATUS, ADDR_RDBK_A, ADDR_RDBK_B: next_bresp = RESP_OKAY;
        default:     next_bresp  = RESP_SLVERR;
      endcase
    end
    if (rd_go)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:   next_rdata = {16'h0, ctrl};
        ADDR_BIAS:   next_rdata = {21'h0, bias};
        ADDR_STATUS: next_rdata = status_word;
        ADDR_RDBK_A: next_rdata = {24'h0, rdbk_a};
        ADDR_RDBK_B: next_rdata = {24'h0, rdbk_b};
        ADDR_OVRD_A: next_rdata = {23'h0, ovrd_a};
        ADDR_OVRD_B: next_rdata = {23'h0, ovrd_b};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl   <= CTRL_RST;
      bias   <= BIAS_RST;
      ovrd_a <= OVRD_RST;
      ovrd_b <= OVRD_RST;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h0000_0000;
    end
    else
    begin
      ctrl   <= next_ctrl;
      bias   <= next_bias;
      ovrd_a <= next_ovrd_a;
      ovrd_b <= next_ovrd_b;
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration run length and sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (ctrl[CTRL_WAIT])
      cal_len = CNT_W'(CYC_1P0);
    else
      case (ctrl[CTRL_REF_LSB +: 2])
        2'h0:    cal_len = CNT_W'(CYC_2P4);
        2'h1:    cal_len = CNT_W'(CYC_2P0);
        2'h2:    cal_len = CNT_W'(CYC_1P5);
        default: cal_len = CNT_W'(CYC_1P0);
      endcase
  end

  synth_cal_engine u_engine (
    .clk       (clk),
    .srst      (srst),
    .start     (start_pulse),
    .synth_on  (!ctrl[CTRL_SYN_PD]),
    .start_bit (ctrl[CTRL_START]),
    .cal_len   (cal_len),
    .dual      (ctrl[CTRL_DUAL]),
    .fsel      (ctrl[CTRL_FSEL]),
    .osc_meas  (osc_meas),
    .pump_meas (pump_meas),
    .busy      (cal_busy),
    .done      (cal_done),
    .slot_osc0 (s_osc0),
    .slot_osc1 (s_osc1),
    .slot_pmp0 (s_pmp0),
    .slot_pmp1 (s_pmp1)
  );

  // ----------------------------------------------------------------------
  // Readback, applied values and lock pin
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_start_d = ctrl[CTRL_START];
    next_rdbk_a  = ctrl[CTRL_FSEL] ? s_osc1 : s_osc0;
    next_rdbk_b  = ctrl[CTRL_FSEL] ? s_pmp1 : s_pmp0;
    if (ovrd_a[OVRD_EN] && ovrd_b[OVRD_EN])
    begin
      next_tune = ovrd_a[7:0];
      next_pump = ovrd_b[7:0];
    end
    else
    begin
      next_tune = next_rdbk_a;
      next_pump = next_rdbk_b;
    end
    case (ctrl[CTRL_LOCK_LSB +: 4])
      LOCK_SRC_CAL:  next_lock_pin = cal_done;
      LOCK_SRC_LOCK: next_lock_pin = continuous_lock_flag;
      default:       next_lock_pin = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      start_d  <= 1'b0;
      rdbk_a   <= 8'h00;
      rdbk_b   <= 8'h00;
      tune     <= 8'h00;
      pump     <= 8'h00;
      lock_pin <= 1'b0;
    end
    else
    begin
      start_d  <= next_start_d;
      rdbk_a   <= next_rdbk_a;
      rdbk_b   <= next_rdbk_b;
      tune     <= next_tune;
      pump     <= next_pump;
      lock_pin <= next_lock_pin;
    end
  end

  assign charge_pump_lock_pin    = lock_pin;
  assign osc_tune                = tune;
  assign pump_current            = pump;
  assign oscillator_bias_setting = bias[BIAS_OSC_LSB +: 4];
  assign lo_buffer_drive         = bias[BIAS_LO_LSB +: 2];
  assign amplifier_buffer_drive  = bias[BIAS_PA_LSB +: 2];
  assign buf_current             = bias[BIAS_BUF];
  assign lna_bias                = bias[BIAS_LNA_LSB +: 2];
  assign rx_pd                   = ctrl[CTRL_RX_PD];
  assign tx_pd                   = ctrl[CTRL_TX_PD];
  assign synth_pd                = ctrl[CTRL_SYN_PD];
  assign xosc_pd                 = ctrl[CTRL_XO_PD];

  lock_pin_a: assert property (@(posedge clk) disable iff (srst)
    (ctrl[CTRL_LOCK_LSB +: 4] == LOCK_SRC_CAL) |=> charge_pump_lock_pin == $past(cal_done))
    else $error("Lock pin does not follow the completion flag.");
  wait_len_a: assert property (@(posedge clk) disable iff (srst)
    ctrl[CTRL_WAIT] |-> cal_len == CNT_W'(CYC_1P0))
    else $error("Fixed wait does not use the worst-case length.");
  readback_sel_a: assert property (@(posedge clk) disable iff (srst)
    ##1 (rdbk_a == ($past(ctrl[CTRL_FSEL]) ? $past(s_osc1) : $past(s_osc0))))
    else $error("Readback does not follow the selected register.");
  override_use_a: assert property (@(posedge clk) disable iff (srst)
    (ovrd_a[OVRD_EN] && ovrd_b[OVRD_EN]) ##1 $stable(ovrd_a) |-> osc_tune == ovrd_a[7:0])
    else $error("Override value not applied.");
  pd_bits_a: assert property (@(posedge clk) disable iff (srst)
    (wr_go && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[1])
      |=> synth_pd == $past(s_axi_wdata[CTRL_SYN_PD]) && rx_pd == $past(s_axi_wdata[CTRL_RX_PD]))
    else $error("Power-down bits not taken from the write.");

endmodule : synth_calibration_power_ctrl

// >>> synth_calibration_power_ctrl_tb.sv
/*
  Self-checking bench for the calibration and power control block.
  Assumes the host model drives the register bus; run lengths are shortened.
*/
`timescale 1ns/100ps
module synth_calibration_power_ctrl_tb;
  import synth_cal_pkg::*;
  localparam int LEN [4] = '{20, 25, 30, 40};
  logic clk = 1'b0, srst = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_arready, s_axi_rvalid, continuous_lock_flag, charge_pump_lock_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr, osc_meas, pump_meas, osc_tune, pump_current;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb, oscillator_bias_setting;
  logic [1:0] s_axi_bresp, s_axi_rresp, lo_buffer_drive, amplifier_buffer_drive, lna_bias, resp;
  logic buf_current, rx_pd, tx_pd, synth_pd, xosc_pd;
  int failures = 0, compares = 0, cycles = 0;

  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures = failures + 1;
      test_done();
    end
  end

  synth_calibration_power_ctrl #(.CYC_2P4(LEN[0]), .CYC_2P0(LEN[1]), .CYC_1P5(LEN[2]),
    .CYC_1P0(LEN[3])) u_synth_calibration_power_ctrl (.clk, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_meas, .pump_meas,
    .continuous_lock_flag, .charge_pump_lock_pin, .osc_tune, .pump_current,
    .oscillator_bias_setting, .lo_buffer_drive, .amplifier_buffer_drive, .buf_current,
    .lna_bias, .rx_pd, .tx_pd, .synth_pd, .xosc_pd);

  synth_host_model u_synth_host_model (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_synth_host_model.wr(a, d, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_synth_host_model.rd(a, rdat, resp);
    chk(rdat, exp);
  endtask : rdc

  // Runs one calibration with the lock pin showing the done flag.
  task automatic cal(input logic [31:0] ctl, input logic [7:0] o, input logic [7:0] p,
                     input int len);
    int n;
    n = 0;
    osc_meas  <= o;
    pump_meas <= p;
    wr(ADDR_CTRL, ctl | 32'h11);
    while (charge_pump_lock_pin !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= len - 3 && n <= len + 3}, 32'h1);
    @(posedge clk);
    chk({16'h0, osc_tune, pump_current}, {16'h0, o, p});
    rdc(ADDR_STATUS, 32'h1);
    wr(ADDR_CTRL, ctl);
    rdc(ADDR_STATUS, 32'h0);
  endtask : cal

  task automatic test_power_down;
    rdc(ADDR_CTRL, 32'h0000F000);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL, 32'h1 << (12 + i));
      chk({28'h0, xosc_pd, synth_pd, tx_pd, rx_pd}, 32'h1 << i);
    end
  endtask : test_power_down

  task automatic test_bias;
    wr(ADDR_BIAS, 32'h414);
    chk({21'h0, lna_bias, buf_current, amplifier_buffer_drive, lo_buffer_drive,
         oscillator_bias_setting}, 32'h414);
    wr(ADDR_BIAS, 32'h538);
    chk({21'h0, lna_bias, buf_current, amplifier_buffer_drive, lo_buffer_drive,
         oscillator_bias_setting}, 32'h538);
  endtask : test_bias

  // Unmapped offsets answer with an error and leave the registers alone.
  task automatic test_unmapped;
    u_synth_host_model.wr(8'h1C, 32'hFFFFFFFF, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    rdc(ADDR_CTRL, 32'h00008000);
    u_synth_host_model.rd(8'h1C, rdat, resp);
    chk({rdat[31:2], resp}, {30'h0, RESP_SLVERR});
  endtask : test_unmapped

  task automatic test_cal_rates;
    for (int i = 0; i < 4; i++)
      cal(32'(i) << CTRL_REF_LSB, 8'h10 + 8'(i), 8'h20 + 8'(i), LEN[i]);
  endtask : test_cal_rates

  task automatic test_slots;
    cal(32'h2, 8'h3C, 8'h4D, LEN[3]);
    rdc(ADDR_RDBK_B, 32'h4D);
    cal(32'h8, 8'hA5, 8'h5A, LEN[0]);
    wr(ADDR_CTRL, 32'h0);
    rdc(ADDR_RDBK_A, 32'h3C);
    wr(ADDR_CTRL, 32'h8);
    rdc(ADDR_RDBK_A, 32'hA5);
    cal(32'h4, 8'h77, 8'h66, LEN[0]);
    rdc(ADDR_RDBK_B, 32'h66);
    wr(ADDR_CTRL, 32'h0);
    rdc(ADDR_RDBK_A, 32'h77);
  endtask : test_slots

  // A start with the synthesiser powered down is refused: no run begins and the status stays clear.
  task automatic test_start_refused;
    wr(ADDR_CTRL, 32'h4011);
    repeat (60) @(posedge clk);
    rdc(ADDR_STATUS, 32'h0);
  endtask : test_start_refused

  task automatic test_lock_source;
    continuous_lock_flag <= 1'b1;
    wr(ADDR_CTRL, 32'h20);
    repeat (3) @(posedge clk);
    chk({31'h0, charge_pump_lock_pin}, 32'h1);
    rdc(ADDR_STATUS, 32'h4);
    wr(ADDR_CTRL, 32'h0);
    @(posedge clk);
    chk({31'h0, charge_pump_lock_pin}, 32'h0);
  endtask : test_lock_source

  task automatic test_override;
    wr(ADDR_OVRD_A, 32'h15A);
    wr(ADDR_OVRD_B, 32'h1C3);
    @(posedge clk);
    chk({16'h0, osc_tune, pump_current}, 32'h5AC3);
  endtask : test_override

  initial
  begin
    {osc_meas, pump_meas, continuous_lock_flag} = 17'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    test_power_down();
    test_bias();
    test_unmapped();
    test_cal_rates();
    test_slots();
    test_start_refused();
    test_lock_source();
    test_override();
    test_done();
  end
endmodule : synth_calibration_power_ctrl_tb

// >>> synth_host_model.sv
/*
  Host model: an AXI4-Lite master that issues one register access at a time.
  Assumes a single clock and a slave that answers on its own schedule.
*/
`timescale 1ns/100ps
module synth_host_model
  import synth_cal_pkg::*;
(
  input  wire logic        clk,           // System clock.
  output logic [7:0]       s_axi_awaddr,  // Write address.
  output logic             s_axi_awvalid, // Write address valid.
  input  wire logic        s_axi_awready, // Write address ready.
  output logic [31:0]      s_axi_wdata,   // Write data.
  output logic [3:0]       s_axi_wstrb,   // Byte strobes.
  output logic             s_axi_wvalid,  // Write data valid.
  input  wire logic        s_axi_wready,  // Write data ready.
  input  wire logic [1:0]  s_axi_bresp,   // Write response.
  input  wire logic        s_axi_bvalid,  // Write response valid.
  output logic             s_axi_bready,  // Write response ready.
  output logic [7:0]       s_axi_araddr,  // Read address.
  output logic             s_axi_arvalid, // Read address valid.
  input  wire logic        s_axi_arready, // Read address ready.
  input  wire logic [31:0] s_axi_rdata,   // Read data.
  input  wire logic [1:0]  s_axi_rresp,   // Read response.
  input  wire logic        s_axi_rvalid,  // Read data valid.
  output logic             s_axi_rready   // Read data ready.
);
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
    s_axi_wdata = 32'h00000000;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left, w_left;
    aw_left = 1'b1;
    w_left  = 1'b1;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // Each channel lets go at the edge that takes it, as a slave may take them apart.
    while (aw_left || w_left)
    begin
      @(posedge clk);
      if (aw_left && s_axi_awready === 1'b1)
      begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1)
      begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : synth_host_model
